// ### hdl/csms_cfg.svh
// Constants for the chip-select merge and stretch block
// ****************************************************************
// ****************************************************************
`ifndef CSMS_CFG_SVH
`define CSMS_CFG_SVH

// ****************************************************************
// Register indices and bus widths
// ****************************************************************
`define CSMS_ADDR_W        12
`define CSMS_DATA_W        32
`define CSMS_REG_W         8
`define CSMS_IDX_STRETCH   8'h5a
`define CSMS_IDX_GP1C      8'h5d
`define CSMS_IDX_GP2C      8'h5f
`define CSMS_IDX_STATUS    8'h60
`define CSMS_REG_RESET     8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CSMS_GP1C_TO_PROG   7
`define CSMS_GP1C_POL       6
`define CSMS_GP1C_TO_SECOND 5
`define CSMS_GP2C_TO_PROG   7
`define CSMS_GP2C_POL       6
`define CSMS_STR_IO_LSB     6
`define CSMS_STR_GP1_LSB    4
`define CSMS_STR_GP2_LSB    2
`define CSMS_STR_PROG_LSB   0
`define CSMS_ST_PHASE_LSB   0
`define CSMS_ST_REMAIN_LSB  2
`define CSMS_ST_PINS_LSB    6

// ****************************************************************
// Timing
// ****************************************************************
`define CSMS_CLK_NS        20
`define CSMS_E_HALF_NS     40
`define CSMS_HALF_CYC      ((`CSMS_E_HALF_NS) / (`CSMS_CLK_NS))
`define CSMS_BUS_CYC       (2 * `CSMS_HALF_CYC)

`endif

// ### hdl/csms_pkg.sv
// Types for the chip-select merge and stretch block
package csms_pkg;

  typedef enum logic [1:0] {
    PH_LOW,
    PH_HIGH,
    PH_STRETCH
  } csms_phase_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_IO,
    SEL_PROG,
    SEL_GP1,
    SEL_GP2
  } csms_match_type;

endpackage

// ### hdl/csms_stretch.sv
// Down counter that times an E-clock stretch in pclk cycles
`timescale 1ns/1ns
module csms_stretch (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [3:0] cycles,
  output logic            busy,
  output logic            last,
  output logic [3:0]      remaining
);

  logic [3:0] remaining_q;
  logic [3:0] remaining_d;

  always_comb begin
    remaining_d = remaining_q;
    if (load) begin
      remaining_d = cycles;
    end else if (remaining_q != 4'h0) begin
      remaining_d = remaining_q - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining_q <= 4'h0;
    end else begin
      remaining_q <= remaining_d;
    end
  end

  assign busy      = remaining_q != 4'h0;
  assign last      = remaining_q == 4'h1;
  assign remaining = remaining_q;

endmodule

// ### hdl/csms_top.sv
// Chip-select routing merge, polarity and E-clock stretch with APB registers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "csms_cfg.svh"
module csms_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`CSMS_ADDR_W-1:0]  paddr,
  input  wire logic [`CSMS_DATA_W-1:0]  pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [`CSMS_DATA_W-1:0]       prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     io_area,
  input  wire logic                     prog_area,
  input  wire logic                     gp1_area,
  input  wire logic                     gp2_area,
  input  wire logic                     io_polarity,
  input  wire logic                     program_polarity,
  output logic                          e_clk,
  output logic                          cpu_hold,
  output logic                          bus_rate_tick,
  output logic                          io_select_pin,
  output logic                          program_select_pin,
  output logic                          general_select_one_pin,
  output logic                          general_select_two_pin
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  function automatic logic reg_hit(
    input logic [`CSMS_ADDR_W-1:0] addr,
    input logic [7:0]              idx
  );
    reg_hit = addr == `CSMS_ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic [1:0] field2(
    input logic [`CSMS_REG_W-1:0] r,
    input int unsigned            lsb
  );
    field2 = r[lsb +: 2];
  endfunction

  // Count of extra bus cycles turned into pclk cycles
  function automatic logic [3:0] stretch_cycles(
    input logic [1:0] count
  );
    stretch_cycles = 4'(count * `CSMS_BUS_CYC);
  endfunction

  // Polarity bit 0 means active low
  function automatic logic drive_level(
    input logic asserted,
    input logic active_high
  );
    drive_level = active_high ? asserted : ~asserted;
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************

  logic [`CSMS_REG_W-1:0] stretch_q;
  logic [`CSMS_REG_W-1:0] stretch_d;
  logic [`CSMS_REG_W-1:0] gp1c_q;
  logic [`CSMS_REG_W-1:0] gp1c_d;
  logic [`CSMS_REG_W-1:0] gp2c_q;
  logic [`CSMS_REG_W-1:0] gp2c_d;
  logic [`CSMS_DATA_W-1:0] prdata_q;
  logic [`CSMS_DATA_W-1:0] prdata_d;
  logic                    pslverr_q;
  logic                    pslverr_d;
  logic                    hit_stretch;
  logic                    hit_gp1c;
  logic                    hit_gp2c;
  logic                    hit_status;
  logic                    mapped;
  logic                    wr_en;
  logic [`CSMS_REG_W-1:0]  status_val;

  assign hit_stretch = reg_hit(paddr, `CSMS_IDX_STRETCH);
  assign hit_gp1c    = reg_hit(paddr, `CSMS_IDX_GP1C);
  assign hit_gp2c    = reg_hit(paddr, `CSMS_IDX_GP2C);
  assign hit_status  = reg_hit(paddr, `CSMS_IDX_STATUS);
  assign mapped      = hit_stretch | hit_gp1c | hit_gp2c | hit_status;

  // Writes land only on the access edge; only the low byte lane holds data
  assign wr_en = psel & penable & pwrite & mapped & pstrb[0];

  always_comb begin
    stretch_d = stretch_q;
    gp1c_d    = gp1c_q;
    gp2c_d    = gp2c_q;
    if (wr_en) begin
      if (hit_stretch) begin
        stretch_d = pwdata[`CSMS_REG_W-1:0];
      end
      if (hit_gp1c) begin
        gp1c_d = pwdata[`CSMS_REG_W-1:0];
      end
      if (hit_gp2c) begin
        gp2c_d = pwdata[`CSMS_REG_W-1:0];
      end
    end
  end

  // Read data is captured in the setup cycle so the access phase never waits
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (psel && !penable) begin
      prdata_d  = '0;
      pslverr_d = ~mapped;
      if (!pwrite) begin
        if (hit_stretch) begin
          prdata_d[`CSMS_REG_W-1:0] = stretch_q;
        end else if (hit_gp1c) begin
          prdata_d[`CSMS_REG_W-1:0] = gp1c_q;
        end else if (hit_gp2c) begin
          prdata_d[`CSMS_REG_W-1:0] = gp2c_q;
        end else if (hit_status) begin
          prdata_d[`CSMS_REG_W-1:0] = status_val;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_q <= `CSMS_REG_RESET;
      gp1c_q    <= `CSMS_REG_RESET;
      gp2c_q    <= `CSMS_REG_RESET;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      stretch_q <= stretch_d;
      gp1c_q    <= gp1c_d;
      gp2c_q    <= gp2c_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign pready  = 1'b1;

  // ****************************************************************
  // Routing merge
  // ****************************************************************

  logic to_second;
  logic one_to_prog;
  logic two_to_prog;
  logic one_to_two;
  logic one_own;
  logic two_own;
  logic prog_asserted;
  logic gp1_asserted;
  logic gp2_asserted;

  assign to_second   = gp1c_q[`CSMS_GP1C_TO_SECOND];
  assign one_to_prog = gp1c_q[`CSMS_GP1C_TO_PROG];
  assign two_to_prog = gp2c_q[`CSMS_GP2C_TO_PROG];

  // Routing to program wins over routing to the second general select,
  // and a second select that is itself routed away leaves the first on its own pin
  assign one_to_two = to_second & ~one_to_prog & ~two_to_prog;
  assign one_own    = ~one_to_prog & ~(to_second & ~two_to_prog);
  assign two_own    = ~two_to_prog;

  // Ranges are taken as disjoint, so the OR never has to arbitrate
  assign prog_asserted = prog_area
                       | (one_to_prog & gp1_area)
                       | (two_to_prog & gp2_area);
  assign gp2_asserted  = two_own & (gp2_area | (one_to_two & gp1_area));
  assign gp1_asserted  = one_own & gp1_area;

  // ****************************************************************
  // Stretch selection
  // ****************************************************************

  csms_pkg::csms_match_type match;
  logic [1:0]               match_count;

  // Stretch belongs to whichever range matched, not to the pin it drives
  always_comb begin
    match       = csms_pkg::SEL_NONE;
    match_count = 2'b00;
    if (io_area) begin
      match       = csms_pkg::SEL_IO;
      match_count = field2(stretch_q, `CSMS_STR_IO_LSB);
    end else if (prog_area) begin
      match       = csms_pkg::SEL_PROG;
      match_count = field2(stretch_q, `CSMS_STR_PROG_LSB);
    end else if (gp1_area) begin
      match       = csms_pkg::SEL_GP1;
      match_count = field2(stretch_q, `CSMS_STR_GP1_LSB);
    end else if (gp2_area) begin
      match       = csms_pkg::SEL_GP2;
      match_count = field2(stretch_q, `CSMS_STR_GP2_LSB);
    end
  end

  // ****************************************************************
  // E clock phase machine
  // ****************************************************************

  csms_pkg::csms_phase_type phase_q;
  csms_pkg::csms_phase_type phase_d;
  logic [1:0]               half_q;
  logic [1:0]               half_d;
  logic                     half_end;
  logic                     st_load;
  logic                     st_busy;
  logic                     st_last;
  logic [3:0]               st_remain;

  assign half_end = half_q == 2'(`CSMS_HALF_CYC - 1);

  always_comb begin
    phase_d = phase_q;
    half_d  = half_q;
    st_load = 1'b0;
    case (phase_q)
      csms_pkg::PH_LOW: begin
        half_d = half_end ? 2'b00 : half_q + 2'b01;
        if (half_end) begin
          phase_d = csms_pkg::PH_HIGH;
        end
      end
      csms_pkg::PH_HIGH: begin
        half_d = half_end ? 2'b00 : half_q + 2'b01;
        if (half_end) begin
          if (match != csms_pkg::SEL_NONE && match_count != 2'b00) begin
            st_load = 1'b1;
            phase_d = csms_pkg::PH_STRETCH;
          end else begin
            phase_d = csms_pkg::PH_LOW;
          end
        end
      end
      csms_pkg::PH_STRETCH: begin
        half_d = 2'b00;
        if (st_last || !st_busy) begin
          phase_d = csms_pkg::PH_LOW;
        end
      end
      default: begin
        phase_d = csms_pkg::PH_LOW;
        half_d  = 2'b00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= csms_pkg::PH_LOW;
      half_q  <= 2'b00;
    end else begin
      phase_q <= phase_d;
      half_q  <= half_d;
    end
  end

  csms_stretch u_stretch (
    .clk       (pclk),
    .rst_n     (presetn),
    .load      (st_load),
    .cycles    (stretch_cycles(match_count)),
    .busy      (st_busy),
    .last      (st_last),
    .remaining (st_remain)
  );

  // ****************************************************************
  // E clock and pin registers
  // ****************************************************************

  logic e_q;
  logic e_d;
  logic io_pin_q;
  logic io_pin_d;
  logic prog_pin_q;
  logic prog_pin_d;
  logic gp1_pin_q;
  logic gp1_pin_d;
  logic gp2_pin_q;
  logic gp2_pin_d;
  logic [3:0] asserted_q;
  logic [3:0] asserted_d;
  logic edge_now;

  // Pins move only when E changes level, and freeze through a stretch
  assign edge_now = (phase_d == csms_pkg::PH_LOW) != (phase_q == csms_pkg::PH_LOW);

  always_comb begin
    e_d        = phase_d != csms_pkg::PH_LOW;
    io_pin_d   = io_pin_q;
    prog_pin_d = prog_pin_q;
    gp1_pin_d  = gp1_pin_q;
    gp2_pin_d  = gp2_pin_q;
    asserted_d = asserted_q;
    if (edge_now) begin
      asserted_d = {io_area, prog_asserted, gp1_asserted, gp2_asserted};
      io_pin_d   = drive_level(io_area, io_polarity);
      prog_pin_d = drive_level(prog_asserted, program_polarity);
      gp1_pin_d  = drive_level(gp1_asserted, gp1c_q[`CSMS_GP1C_POL]);
      gp2_pin_d  = drive_level(gp2_asserted, gp2c_q[`CSMS_GP2C_POL]);
    end
  end

  // Reset levels are the inactive levels of active-low pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_q        <= 1'b0;
      io_pin_q   <= 1'b1;
      prog_pin_q <= 1'b1;
      gp1_pin_q  <= 1'b1;
      gp2_pin_q  <= 1'b1;
      asserted_q <= 4'h0;
    end else begin
      e_q        <= e_d;
      io_pin_q   <= io_pin_d;
      prog_pin_q <= prog_pin_d;
      gp1_pin_q  <= gp1_pin_d;
      gp2_pin_q  <= gp2_pin_d;
      asserted_q <= asserted_d;
    end
  end

  assign e_clk                  = e_q;
  assign cpu_hold               = phase_q == csms_pkg::PH_STRETCH;
  assign io_select_pin          = io_pin_q;
  assign program_select_pin     = prog_pin_q;
  assign general_select_one_pin = gp1_pin_q;
  assign general_select_two_pin = gp2_pin_q;

  // ****************************************************************
  // Free-running bus rate tick
  // ****************************************************************

  logic [2:0] rate_q;
  logic [2:0] rate_d;
  logic       tick_q;
  logic       tick_d;

  // Timers and baud generators use this, never E, so a stretch cannot slow them
  always_comb begin
    if (rate_q == 3'(`CSMS_BUS_CYC - 1)) begin
      rate_d = 3'h0;
      tick_d = 1'b1;
    end else begin
      rate_d = rate_q + 3'h1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      tick_q <= tick_d;
    end
  end

  assign bus_rate_tick = tick_q;

  // ****************************************************************
  // Status word
  // ****************************************************************

  logic [1:0] phase_code;

  always_comb begin
    case (phase_q)
      csms_pkg::PH_LOW:     phase_code = 2'h0;
      csms_pkg::PH_HIGH:    phase_code = 2'h1;
      csms_pkg::PH_STRETCH: phase_code = 2'h2;
      default:              phase_code = 2'h3;
    endcase
  end

  always_comb begin
    status_val = '0;
    status_val[`CSMS_ST_PHASE_LSB +: 2]  = phase_code;
    status_val[`CSMS_ST_REMAIN_LSB +: 4] = st_remain;
    // Asserted state of program and first general
    status_val[`CSMS_ST_PINS_LSB +: 2]   = asserted_q[2:1];
  end

endmodule

// ### test/csms_top_chk.sv
// Port-level assertions for the chip-select merge and stretch block
`timescale 1ns/1ns
`include "csms_cfg.svh"
module csms_top_chk (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`CSMS_ADDR_W-1:0] paddr,
  input wire logic [`CSMS_DATA_W-1:0] pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    io_area,
  input wire logic                    prog_area,
  input wire logic                    gp1_area,
  input wire logic                    gp2_area,
  input wire logic                    io_polarity,
  input wire logic                    e_clk,
  input wire logic                    cpu_hold,
  input wire logic                    bus_rate_tick,
  input wire logic                    io_select_pin,
  input wire logic                    program_select_pin,
  input wire logic                    general_select_one_pin,
  input wire logic                    general_select_two_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Shadow of the stretch register and length of each E-high phase
  // ****************************************************************
  logic [7:0] str_q, str_d, hi_q, hi_d;
  logic [1:0] n_exp;
  logic       mapped;
  assign mapped = paddr == 12'h168 || paddr == 12'h174 || paddr == 12'h17c || paddr == 12'h180;
  always_comb begin
    str_d = str_q;
    if (psel && penable && pwrite && pstrb[0] && paddr == 12'h168) begin
      str_d = pwdata[7:0];
    end
    hi_d = e_clk ? hi_q + 8'h01 : 8'h00;
    // Later tests win, so io has the highest priority
    n_exp = 2'h0;
    if (gp2_area) n_exp = str_q[`CSMS_STR_GP2_LSB +: 2];
    if (gp1_area) n_exp = str_q[`CSMS_STR_GP1_LSB +: 2];
    if (prog_area) n_exp = str_q[`CSMS_STR_PROG_LSB +: 2];
    if (io_area) n_exp = str_q[`CSMS_STR_IO_LSB +: 2];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      str_q <= 8'h00;
      hi_q  <= 8'h00;
    end else begin
      str_q <= str_d;
      hi_q  <= hi_d;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_tick_period: assert property (bus_rate_tick |=> !bus_rate_tick [*3] ##1 bus_rate_tick)
    else $error("bus rate tick not every four cycles");
  a_e_low_two: assert property ($fell(e_clk) |=> !e_clk ##1 e_clk)
    else $error("E low phase not two cycles");
  a_e_high_min: assert property ($rose(e_clk) |=> e_clk)
    else $error("E high phase too short");
  a_stretch_len: assert property (!e_clk && hi_q != 8'h00 |->
    hi_q == 8'h02 + {n_exp, 2'b00})
    else $error("E high length does not match matched select stretch");
  a_hold_start: assert property ($rose(cpu_hold) |->
    e_clk && $past(e_clk, 2) && !$past(e_clk, 3))
    else $error("hold does not start after two E high cycles");
  a_hold_in_high: assert property (cpu_hold |-> e_clk)
    else $error("hold outside E high");
  a_pins_on_e: assert property (!$stable({io_select_pin, program_select_pin,
    general_select_one_pin, general_select_two_pin}) |-> !$stable(e_clk))
    else $error("select pin changed away from an E edge");
  a_io_level: assert property ($rose(e_clk) |->
    io_select_pin == ~($past(io_area) ^ $past(io_polarity)))
    else $error("io select pin level wrong");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error for unmapped address");
  a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr && pready)
    else $error("error or wait on mapped register");
  cover property (!e_clk && hi_q == 8'h0e);
  cover property ($rose(cpu_hold));
  cover property (psel && penable && pslverr);
endmodule

// ### test/csms_mem_model.sv
// Passive model of the expansion-bus devices watching E and the select pins
`timescale 1ns/1ns
module csms_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       e_clk,
  input  wire logic [3:0] pins,
  output logic            done,
  output logic [7:0]      hi_len,
  output logic [3:0]      pins_seen
);
  // A device only trusts the selects while E is high, so they are captured there
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 8'h00;
      done      <= 1'b0;
      hi_len    <= 8'h00;
      pins_seen <= 4'hf;
    end else begin
      done <= !e_clk && cnt_q != 8'h00;
      if (e_clk) begin
        cnt_q     <= cnt_q + 8'h01;
        pins_seen <= pins;
      end else begin
        cnt_q <= 8'h00;
        if (cnt_q != 8'h00) hi_len <= cnt_q;
      end
    end
  end
endmodule

// ### test/testbench.sv
// Self-checking testbench for the chip-select merge and stretch block
`timescale 1ns/1ns
`include "csms_cfg.svh"
bind csms_top csms_top_chk u_csms_top_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .io_area(io_area), .prog_area(prog_area), .gp1_area(gp1_area), .gp2_area(gp2_area),
  .io_polarity(io_polarity), .e_clk(e_clk), .cpu_hold(cpu_hold),
  .bus_rate_tick(bus_rate_tick), .io_select_pin(io_select_pin),
  .program_select_pin(program_select_pin), .general_select_one_pin(general_select_one_pin),
  .general_select_two_pin(general_select_two_pin));
module testbench;
  typedef struct packed {
    logic [3:0] pins;
    logic [7:0] len;
  } csms_note_type;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, dum_err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, dum_rd;
  logic [3:0]    pstrb, ar, pins_seen;
  logic          io_area, prog_area, gp1_area, gp2_area, io_polarity, program_polarity;
  logic          e_clk, cpu_hold, bus_rate_tick, done, io_pin, prog_pin, gp1_pin, gp2_pin;
  logic [7:0]    hi_len, seed, c1, c2, cs;
  int            err_total, check_count;
  csms_note_type note_q[$];
  csms_note_type note;
  csms_top u_csms_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_area(io_area), .prog_area(prog_area),
    .gp1_area(gp1_area), .gp2_area(gp2_area), .io_polarity(io_polarity),
    .program_polarity(program_polarity), .e_clk(e_clk), .cpu_hold(cpu_hold),
    .bus_rate_tick(bus_rate_tick), .io_select_pin(io_pin), .program_select_pin(prog_pin),
    .general_select_one_pin(gp1_pin), .general_select_two_pin(gp2_pin));
  csms_mem_model u_csms_mem_model (.pclk(pclk), .presetn(presetn), .e_clk(e_clk),
    .pins({io_pin, prog_pin, gp1_pin, gp2_pin}), .done(done), .hi_len(hi_len),
    .pins_seen(pins_seen));
  always #(`CSMS_CLK_NS / 2) pclk = ~pclk;
  // ****************************************************************
  // Checking and stimulus helpers
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err_exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, 4'h0, rd, err);
    check("pslverr", {31'h0, err}, {31'h0, err_exp});
    if (!err_exp) check("prdata", rd, exp);
  endtask
  function automatic logic [3:0] exp_pins(input logic [7:0] g1c, input logic [7:0] g2c,
                                          input logic [3:0] a);
    logic p1, d2, p2, ap, a1, a2;
    p1 = g1c[`CSMS_GP1C_TO_PROG];
    d2 = g1c[`CSMS_GP1C_TO_SECOND];
    p2 = g2c[`CSMS_GP2C_TO_PROG];
    ap = a[2] | (p1 & a[1]) | (p2 & a[0]);
    a1 = a[1] & ~p1 & ~(d2 & ~p2);
    a2 = ~p2 & (a[0] | (a[1] & d2 & ~p1));
    return {~(a[3] ^ io_polarity), ~(ap ^ program_polarity),
            ~(a1 ^ g1c[`CSMS_GP1C_POL]), ~(a2 ^ g2c[`CSMS_GP2C_POL])};
  endfunction
  function automatic logic [7:0] exp_len(input logic [7:0] s, input logic [3:0] a);
    logic [1:0] n;
    n = 2'h0;
    if (a[0]) n = s[`CSMS_STR_GP2_LSB +: 2];
    if (a[1]) n = s[`CSMS_STR_GP1_LSB +: 2];
    if (a[2]) n = s[`CSMS_STR_PROG_LSB +: 2];
    if (a[3]) n = s[`CSMS_STR_IO_LSB +: 2];
    return 8'(`CSMS_HALF_CYC + `CSMS_BUS_CYC * n);
  endfunction
  // ****************************************************************
  // Result monitor and watchdog
  // ****************************************************************
  always @(posedge pclk) begin
    if (done === 1'b1 && note_q.size() > 0) begin
      note = note_q.pop_front();
      check("pins", {28'h0, pins_seen}, {28'h0, note.pins});
      check("e_high", {24'h0, hi_len}, {24'h0, note.len});
    end
  end
  // Over twenty times the expected run length
  initial begin
    #(`CSMS_CLK_NS * 20000);
    err_total++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {io_area, prog_area, gp1_area, gp2_area, io_polarity, program_polarity} = '0;
    seed = 8'h57;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h168, 32'h0, 1'b0);
    rd_chk(12'h174, 32'h0, 1'b0);
    rd_chk(12'h17c, 32'h0, 1'b0);
    rd_chk(12'h000, 32'h0, 1'b1);
    for (int r = 0; r < 8; r++) begin
      seed = lfsr(seed);
      c1 = {r[1], seed[6], r[2], seed[4:0]};
      seed = lfsr(seed);
      c2 = {r[0], seed[6:0]};
      seed = lfsr(seed);
      cs = seed;
      apb(1'b1, 12'h174, {seed, seed, seed, c1}, 4'hf, dum_rd, dum_err);
      apb(1'b1, 12'h17c, {seed, seed, seed, c2}, 4'hf, dum_rd, dum_err);
      apb(1'b1, 12'h168, {seed, seed, seed, cs}, 4'hf, dum_rd, dum_err);
      rd_chk(12'h174, {24'h0, c1}, 1'b0);
      rd_chk(12'h17c, {24'h0, c2}, 1'b0);
      rd_chk(12'h168, {24'h0, cs}, 1'b0);
      io_polarity      <= seed[0];
      program_polarity <= seed[1];
      for (int a = 0; a < 5; a++) begin
        ar = 4'b1000 >> a;
        @(negedge e_clk);
        @(posedge pclk);
        {io_area, prog_area, gp1_area, gp2_area} <= ar;
        @(posedge e_clk);
        note_q.push_back({exp_pins(c1, c2, ar), exp_len(cs, ar)});
      end
    end
    // Lane zero disabled: the write must leave the register untouched
    apb(1'b1, 12'h168, 32'h0000_00ff, 4'he, dum_rd, dum_err);
    rd_chk(12'h168, {24'h0, cs}, 1'b0);
    // Status is read-only; with no area and no stretch only the phase low bit may vary
    apb(1'b1, 12'h180, 32'hffff_ffff, 4'hf, dum_rd, dum_err);
    apb(1'b0, 12'h180, 32'h0, 4'h0, dum_rd, dum_err);
    check("status", dum_rd & 32'hffff_fffe, 32'h0);
    check("status_err", {31'h0, dum_err}, 32'h0);
    for (int i = 0; i < 200 && note_q.size() != 0; i++) @(posedge pclk);
    check("notes_left", 32'(note_q.size()), 32'h0);
    stop_test();
  end
endmodule
